// ==== hdl/wkt_pkg.sv ====
// wake timer package: register map, field layout, reset values, timing
// assumes a 50 MHz system clock and 32.768 kHz reference ticks
package wkt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] WKT_OFS_CONFIG = 8'h00;
  localparam logic [7:0] WKT_OFS_MANT = 8'h04;
  localparam logic [7:0] WKT_OFS_EXPO = 8'h08;
  localparam logic [7:0] WKT_OFS_LISTEN = 8'h0c;
  localparam logic [7:0] WKT_OFS_THRESH = 8'h10;
  localparam logic [7:0] WKT_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] WKT_OFS_FLAGS = 8'h18;
  localparam logic [7:0] WKT_OFS_FLAGS_RC = 8'h1c;
  localparam logic [7:0] WKT_OFS_CMD = 8'h20;
  localparam logic [7:0] WKT_OFS_STATE = 8'h24;

  // ----------------------------------------------------------------
  // wake_config_property fields
  // ----------------------------------------------------------------
  localparam int WKT_CFG_EN = 0;
  localparam int WKT_CFG_CAL_EN = 1;
  localparam int WKT_CFG_CAL_LO = 2;
  localparam int WKT_CFG_LBD_EN = 5;
  localparam int WKT_CFG_LDC_RX = 6;
  localparam int WKT_CFG_LDC_TX = 7;
  localparam int WKT_CFG_SRC_XT = 8;
  localparam int WKT_CFG_LBD_PIN = 9;

  // event flag bits, shared by flags and chip_event_irq_enable
  localparam int WKT_EV_WAKE = 0;
  localparam int WKT_EV_RX_PKT = 1;
  localparam int WKT_EV_TX_SENT = 2;
  localparam int WKT_EV_LOW_BATT = 3;
  localparam int WKT_EV_CAL_DONE = 4;

  // command bits
  localparam int WKT_CMD_BOOT = 0;
  localparam int WKT_CMD_WAKE_UP = 1;
  localparam int WKT_CMD_SLEEP = 2;
  localparam int WKT_CMD_STOP = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] WKT_RST_CONFIG = 10'h000;
  localparam logic [15:0] WKT_RST_MANT = 16'h0001;
  localparam logic [3:0] WKT_RST_EXPO = 4'h0;
  localparam logic [7:0] WKT_RST_LISTEN = 8'h01;
  localparam logic [4:0] WKT_RST_THRESH = 5'h00;
  localparam logic [7:0] WKT_RST_TRIM = 8'h80;

  // ----------------------------------------------------------------
  // timing and scale
  // ----------------------------------------------------------------
  localparam int WKT_CLK_HZ = 50000000;
  localparam int WKT_REF_HZ = 32768;
  localparam int WKT_TICK_MULT = 4;
  localparam int WKT_XO_SETTLE_US = 250;
  localparam int WKT_XO_SETTLE_CYC = WKT_XO_SETTLE_US * (WKT_CLK_HZ / 1000000);
  localparam int WKT_CAL_TICKS = 32;
  localparam int WKT_CAL_EXPECT = (WKT_CLK_HZ / WKT_REF_HZ) * WKT_CAL_TICKS;
  localparam int WKT_WIN_MAX = 2;
  localparam int WKT_LBD_BASE_MV = 1500;
  localparam int WKT_LBD_STEP_MV = 50;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WKT_LDC_OFF, WKT_LDC_RX, WKT_LDC_TX} wkt_ldc_type;
  typedef enum logic [1:0] {WKT_CAL_IDLE, WKT_CAL_XO, WKT_CAL_ARM, WKT_CAL_MEAS} wkt_cal_type;

endpackage : wkt_pkg

// ==== hdl/wkt_sync_edge.sv ====
// two-stage synchroniser with rising-edge pulse for a 32 kHz clock pin
// assumes the pin is slow against CLK, so no edge is missed
`timescale 1ns/10ps
`default_nettype none
module wkt_sync_edge (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // pin and result
  input wire logic PIN,
  output logic RISE
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } wkt_se_type;

  wkt_se_type st;
  wkt_se_type next_st;

  // meta feeds only sync; edge is taken between sync and last
  always_comb begin
    next_st.meta = PIN;
    next_st.sync = st.meta;
    next_st.last = st.sync;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RISE = st.sync & ~st.last;

endmodule : wkt_sync_edge
`default_nettype wire

// ==== hdl/wkt_top.sv ====
// wake period timer with duty-cycled listen/transmit and battery check
// assumes an APB master on CLK and 32 kHz clock pins from outside
`timescale 1ns/10ps
`default_nettype none
module wkt_top
  import wkt_pkg::*;
#(
  parameter int XO_SETTLE_CYCLES = wkt_pkg::WKT_XO_SETTLE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // 32 kHz clock pins
  input wire logic RC_CLK,
  input wire logic XT_CLK,
  // radio events from the packet handler
  input wire logic PREAMBLE_OK,
  input wire logic SYNC_OK,
  input wire logic PKT_OK,
  input wire logic RX_FAULT,
  input wire logic TX_DONE,
  // battery voltage in mV from the auxiliary converter
  input wire logic [11:0] BATT_MV,
  // radio and clock control
  output logic RX_ON,
  output logic TX_START,
  output logic XO_ON,
  output logic [7:0] RC_TRIM,
  // event outputs
  output logic LOW_BATT_PIN,
  output logic INTERRUPT_REQUEST_LINE_N
);

  typedef struct packed {
    logic [9:0] cfg;
    logic [15:0] mant;
    logic [3:0] expo;
    logic [7:0] win_len;
    logic [4:0] thresh;
    logic [4:0] irq_en;
    logic [4:0] flags;
    logic irq_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic run;
    wkt_ldc_type duty_cycled_listen;
    wkt_cal_type cal;
    logic [17:0] pre_cnt;
    logic [15:0] per_cnt;
    logic [17:0] win_pre;
    logic [7:0] win_cnt;
    logic [1:0] win_used;
    logic extend;
    logic [7:0] exp_cnt;
    logic [13:0] xo_cnt;
    logic [16:0] cal_cyc;
    logic [5:0] cal_tick;
    logic [7:0] trim;
    logic xo_on;
    logic rx_on;
    logic tx_start;
    logic lbd_pin;
  } wkt_state_type;

  wkt_state_type st;
  wkt_state_type next_st;

  logic rc_tick;
  logic xt_tick;
  logic tick;
  logic expire;
  logic win_end;
  logic wr_acc;
  logic rd_acc;
  logic [4:0] set_ev;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reference ticks per mantissa step: four times two to the exponent
  function automatic logic [17:0] wkt_scale(input logic [3:0] e);
    return 18'(WKT_TICK_MULT) << e;
  endfunction : wkt_scale

  // threshold code to millivolts
  function automatic logic [11:0] wkt_thresh_mv(input logic [4:0] code);
    return 12'(WKT_LBD_BASE_MV) + 12'(WKT_LBD_STEP_MV) * {7'h00, code};
  endfunction : wkt_thresh_mv

  // ----------------------------------------------------------------
  // clock pin synchronisers
  // ----------------------------------------------------------------
  wkt_sync_edge u_rc_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .PIN(RC_CLK),
    .RISE(rc_tick)
  );

  wkt_sync_edge u_xt_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .PIN(XT_CLK),
    .RISE(xt_tick)
  );

  // bus strobes: zero-wait slave, access completes when PREADY is seen
  assign wr_acc = PSEL & PENABLE & st.pready & PWRITE;
  assign rd_acc = PSEL & PENABLE & st.pready & ~PWRITE;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    set_ev = 5'h00;
    tick = st.cfg[WKT_CFG_SRC_XT] ? xt_tick : rc_tick;
    expire = 1'b0;
    win_end = 1'b0;
    next_st.tx_start = 1'b0;

    // register writes
    if (wr_acc) begin
      if (PADDR == WKT_OFS_CONFIG) begin
        next_st.cfg = PWDATA[9:0];
      end else if (PADDR == WKT_OFS_MANT) begin
        next_st.mant = PWDATA[15:0];
      end else if (PADDR == WKT_OFS_EXPO) begin
        next_st.expo = PWDATA[3:0];
      end else if (PADDR == WKT_OFS_LISTEN) begin
        next_st.win_len = PWDATA[7:0];
      end else if (PADDR == WKT_OFS_THRESH) begin
        next_st.thresh = PWDATA[4:0];
      end else if (PADDR == WKT_OFS_IRQ_EN) begin
        next_st.irq_en = PWDATA[4:0];
      end else if (PADDR == WKT_OFS_FLAGS) begin
        next_st.flags = st.flags & ~PWDATA[4:0];
      end else if (PADDR == WKT_OFS_CMD) begin
        // start only when enabled on sleep entry
        if (PWDATA[WKT_CMD_SLEEP] && st.cfg[WKT_CFG_EN]) begin
          next_st.run = 1'b1;
          next_st.pre_cnt = 18'h00000;
          next_st.per_cnt = 16'h0000;
        end
        if (PWDATA[WKT_CMD_STOP]) begin
          next_st.run = 1'b0;
        end
        // calibrate on boot and shutdown exit
        if ((PWDATA[WKT_CMD_BOOT] || PWDATA[WKT_CMD_WAKE_UP]) && st.cal == WKT_CAL_IDLE) begin
          next_st.cal = WKT_CAL_XO;
          next_st.xo_cnt = 14'h0000;
        end
      end
    end
    // reading the flag snapshot clears what was read
    if (rd_acc && PADDR == WKT_OFS_FLAGS_RC) begin
      next_st.flags = st.flags & ~st.prdata[4:0];
    end
    // clearing enable stops the timer as well
    if (!next_st.cfg[WKT_CFG_EN]) begin
      next_st.run = 1'b0;
    end

    // period counter, prescaled per mantissa step
    if (st.run && tick) begin
      if (st.pre_cnt + 18'h00001 >= wkt_scale(st.expo)) begin
        next_st.pre_cnt = 18'h00000;
        if ({1'b0, st.per_cnt} + 17'h00001 >= {1'b0, st.mant}) begin
          next_st.per_cnt = 16'h0000;
          expire = 1'b1;
        end else begin
          next_st.per_cnt = st.per_cnt + 16'h0001;
        end
      end else begin
        next_st.pre_cnt = st.pre_cnt + 18'h00001;
      end
    end

    if (expire) begin
      set_ev[WKT_EV_WAKE] = 1'b1;
    end

    if (expire && st.cfg[WKT_CFG_LBD_EN]) begin
      // threshold in 50 mV steps from 1.5 V
      if (BATT_MV < wkt_thresh_mv(st.thresh)) begin
        // route to pin or to the event flags
        if (st.cfg[WKT_CFG_LBD_PIN]) begin
          next_st.lbd_pin = 1'b1;
        end else begin
          set_ev[WKT_EV_LOW_BATT] = 1'b1;
        end
      end else begin
        next_st.lbd_pin = 1'b0;
      end
    end

    // listen window timing in reference ticks
    if (st.duty_cycled_listen == WKT_LDC_RX && tick) begin
      if (st.win_pre + 18'h00001 >= wkt_scale(st.expo)) begin
        next_st.win_pre = 18'h00000;
        if (st.win_cnt + 8'h01 >= st.win_len) begin
          next_st.win_cnt = 8'h00;
          win_end = 1'b1;
        end else begin
          next_st.win_cnt = st.win_cnt + 8'h01;
        end
      end else begin
        next_st.win_pre = st.win_pre + 18'h00001;
      end
    end

    // duty-cycled listen and transmit sequencing
    case (st.duty_cycled_listen)
      WKT_LDC_OFF: begin
        if (expire && st.cfg[WKT_CFG_LDC_RX]) begin
          next_st.duty_cycled_listen = WKT_LDC_RX;
          next_st.rx_on = 1'b1;
          next_st.win_pre = 18'h00000;
          next_st.win_cnt = 8'h00;
          next_st.win_used = 2'd1;
          next_st.extend = 1'b0;
        end else if (expire && st.cfg[WKT_CFG_LDC_TX]) begin
          next_st.duty_cycled_listen = WKT_LDC_TX;
          next_st.tx_start = 1'b1;
        end
      end
      WKT_LDC_RX: begin
        if (PKT_OK) begin
          set_ev[WKT_EV_RX_PKT] = 1'b1;
          next_st.duty_cycled_listen = WKT_LDC_OFF;
          next_st.rx_on = 1'b0;
        end else begin
          // preamble or sync asks for another window
          if (PREAMBLE_OK || SYNC_OK) begin
            next_st.extend = 1'b1;
          end
          // a receive fault cancels the request for another window
          if (RX_FAULT) begin
            next_st.extend = 1'b0;
          end
          if (win_end) begin
            if (next_st.extend && st.win_used < 2'(WKT_WIN_MAX)) begin
              next_st.win_used = st.win_used + 2'd1;
              next_st.extend = 1'b0;
            end else begin
              next_st.duty_cycled_listen = WKT_LDC_OFF;
              next_st.rx_on = 1'b0;
            end
          end
        end
      end
      WKT_LDC_TX: begin
        // flag and return at once after sending
        if (TX_DONE) begin
          set_ev[WKT_EV_TX_SENT] = 1'b1;
          next_st.duty_cycled_listen = WKT_LDC_OFF;
        end
      end
      default: begin
        next_st.duty_cycled_listen = WKT_LDC_OFF;
        next_st.rx_on = 1'b0;
      end
    endcase

    if (expire && st.cfg[WKT_CFG_CAL_EN]) begin
      if (st.exp_cnt + 8'h01 >= (8'h01 << st.cfg[WKT_CFG_CAL_LO +: 3])) begin
        next_st.exp_cnt = 8'h00;
        if (next_st.cal == WKT_CAL_IDLE) begin
          next_st.cal = WKT_CAL_XO;
          next_st.xo_cnt = 14'h0000;
        end
      end else begin
        next_st.exp_cnt = st.exp_cnt + 8'h01;
      end
    end

    // crystal start, measure RC against the system clock, trim
    case (st.cal)
      WKT_CAL_IDLE: begin
        next_st.xo_on = (next_st.cal != WKT_CAL_IDLE);
      end
      WKT_CAL_XO: begin
        next_st.xo_on = 1'b1;
        if (st.xo_cnt >= 14'(XO_SETTLE_CYCLES - 1)) begin
          next_st.cal = WKT_CAL_ARM;
        end else begin
          next_st.xo_cnt = st.xo_cnt + 14'h0001;
        end
      end
      WKT_CAL_ARM: begin
        // align the window to an RC edge
        if (rc_tick) begin
          next_st.cal = WKT_CAL_MEAS;
          next_st.cal_cyc = 17'h00000;
          next_st.cal_tick = 6'h00;
        end
      end
      WKT_CAL_MEAS: begin
        next_st.cal_cyc = st.cal_cyc + 17'h00001;
        if (rc_tick) begin
          if (st.cal_tick + 6'h01 >= 6'(WKT_CAL_TICKS)) begin
            // slow RC gives more system cycles: speed it up
            if (st.cal_cyc > 17'(WKT_CAL_EXPECT) && st.trim != 8'hff) begin
              next_st.trim = st.trim + 8'h01;
            end else if (st.cal_cyc < 17'(WKT_CAL_EXPECT) && st.trim != 8'h00) begin
              next_st.trim = st.trim - 8'h01;
            end
            next_st.cal = WKT_CAL_IDLE;
            next_st.xo_on = 1'b0;
            set_ev[WKT_EV_CAL_DONE] = 1'b1;
          end else begin
            next_st.cal_tick = st.cal_tick + 6'h01;
          end
        end
      end
      default: begin
        next_st.cal = WKT_CAL_IDLE;
      end
    endcase

    // sticky flags: a new event wins over a clear in the same cycle
    next_st.flags = next_st.flags | set_ev;
    next_st.irq_n = ~|(next_st.flags & next_st.irq_en);

    // apb answer prepared in the setup cycle, shown in the access cycle
    next_st.pready = PSEL & ~PENABLE;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h00000000;
    if (PSEL && !PENABLE) begin
      if (PADDR == WKT_OFS_CONFIG) begin
        next_st.prdata = {22'h000000, st.cfg};
      end else if (PADDR == WKT_OFS_MANT) begin
        next_st.prdata = {16'h0000, st.mant};
      end else if (PADDR == WKT_OFS_EXPO) begin
        next_st.prdata = {28'h0000000, st.expo};
      end else if (PADDR == WKT_OFS_LISTEN) begin
        next_st.prdata = {24'h000000, st.win_len};
      end else if (PADDR == WKT_OFS_THRESH) begin
        next_st.prdata = {27'h0000000, st.thresh};
      end else if (PADDR == WKT_OFS_IRQ_EN) begin
        next_st.prdata = {27'h0000000, st.irq_en};
      end else if (PADDR == WKT_OFS_FLAGS || PADDR == WKT_OFS_FLAGS_RC) begin
        next_st.prdata = {27'h0000000, next_st.flags};
      end else if (PADDR == WKT_OFS_CMD) begin
        next_st.prdata = 32'h00000000;
      end else if (PADDR == WKT_OFS_STATE) begin
        next_st.prdata = {13'h0000, st.lbd_pin, st.cal, st.duty_cycled_listen, st.run, st.win_used, st.trim, 3'h0};
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st <= '0;
      st.cfg <= WKT_RST_CONFIG;
      st.mant <= WKT_RST_MANT;
      st.expo <= WKT_RST_EXPO;
      st.win_len <= WKT_RST_LISTEN;
      st.thresh <= WKT_RST_THRESH;
      st.trim <= WKT_RST_TRIM;
      st.irq_n <= 1'b1;
      st.duty_cycled_listen <= WKT_LDC_OFF;
      st.cal <= WKT_CAL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign RX_ON = st.rx_on;
  assign TX_START = st.tx_start;
  assign XO_ON = st.xo_on;
  assign RC_TRIM = st.trim;
  assign LOW_BATT_PIN = st.lbd_pin;
  assign INTERRUPT_REQUEST_LINE_N = st.irq_n;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking wkt_cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  irq_line_a: assert property (INTERRUPT_REQUEST_LINE_N == ~|(st.flags & st.irq_en))
    else $error("interrupt line disagrees with flags");
  wake_flag_a: assert property (expire |=> st.flags[WKT_EV_WAKE])
    else $error("wake flag not set on expiry");
  run_needs_en_a: assert property (st.run |-> st.cfg[WKT_CFG_EN])
    else $error("timer running while disabled");
  tx_on_wake_a: assert property (expire && st.duty_cycled_listen == WKT_LDC_OFF && !st.cfg[WKT_CFG_LDC_RX]
    && st.cfg[WKT_CFG_LDC_TX] |=> TX_START ##1 !TX_START)
    else $error("transmit not started on wake");
  rx_on_wake_a: assert property (expire && st.duty_cycled_listen == WKT_LDC_OFF && st.cfg[WKT_CFG_LDC_RX]
    |=> RX_ON)
    else $error("receiver not on after wake");
  window_limit_a: assert property (st.win_used <= 2'd2)
    else $error("more than two listen windows");
  xo_during_cal_a: assert property (st.cal inside {WKT_CAL_ARM, WKT_CAL_MEAS} |-> XO_ON)
    else $error("crystal off during calibration");
  boot_cal_a: assert property (wr_acc && PADDR == WKT_OFS_CMD && PWDATA[WKT_CMD_BOOT]
    && st.cal == WKT_CAL_IDLE |=> st.cal == WKT_CAL_XO ##1 XO_ON)
    else $error("boot did not start calibration");
  lbd_gated_a: assert property ($rose(st.flags[WKT_EV_LOW_BATT]) |-> $past(st.cfg[WKT_CFG_LBD_EN])
    && $past(st.run))
    else $error("low battery flag without detector enabled");
  trim_step_a: assert property (st.trim != $past(st.trim) |-> $past(st.cal) == WKT_CAL_MEAS)
    else $error("trim changed outside calibration");

  wake_expiry_c: cover property (expire ##[1:3] !INTERRUPT_REQUEST_LINE_N);
  window_ext_c: cover property (st.duty_cycled_listen == WKT_LDC_RX && st.win_used == 2'd2);
  cal_done_c: cover property (st.cal == WKT_CAL_MEAS ##1 st.cal == WKT_CAL_IDLE);

endmodule : wkt_top
`default_nettype wire

// ==== sim/wkt_radio_model.sv ====
// radio stand-in for the wake timer
// assumes the timer's clock and one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module wkt_radio_model #(
  parameter int DONE_DLY = 6
) (
  // clock and timer controls
  input wire logic CLK,
  input wire logic RX_ON,
  input wire logic TX_START,
  input wire logic SEND_PKT,
  // radio events
  output logic PKT_OK,
  output logic TX_DONE
);
  int rx_cnt = 0;
  int tx_cnt = 0;
  always @(posedge CLK) begin
    rx_cnt <= RX_ON ? rx_cnt + 1 : 0;
    PKT_OK <= SEND_PKT && RX_ON && rx_cnt == 30;
  end
  always @(posedge CLK) begin
    tx_cnt <= TX_START ? DONE_DLY : (tx_cnt > 0 ? tx_cnt - 1 : 0);
    TX_DONE <= tx_cnt == 1;
  end
endmodule : wkt_radio_model
`default_nettype wire

// ==== sim/wkt_top_tb.sv ====
// bench: apb host, scaled rc clock, radio stand-in
// assumes design and radio model compiled first
`timescale 1ns/10ps
`default_nettype none
module wkt_top_tb;
  import wkt_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rc_clk = 0, send_pkt = 0;
  logic xt_clk = 0, pre_ok = 0, sync_ok = 0, rx_flt = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [11:0] batt_mv = 12'hfff;
  logic pready, pslverr, err, rx_on, tx_start, xo_on, irq_n, pkt_ok, tx_done, lbd_pin;
  logic [7:0] trim;
  int err_count = 0, n_tests = 0, ticks = 0, n_tx = 0, seed = 82, mant, expo, lsn, thr, xticks = 0;
  always #10 clk = ~clk;
  // rc tick every 40 cycles, short runs
  always #400 rc_clk = ~rc_clk;
  always @(posedge rc_clk) ticks++;
  // crystal pin on a slower period, phase kept clear of the sleep edge
  always #600 xt_clk = ~xt_clk;
  always @(posedge xt_clk) xticks++;
  always @(posedge clk) if (tx_start === 1'b1) n_tx++;
  wkt_top #(.XO_SETTLE_CYCLES(20)) i_wkt_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RC_CLK(rc_clk), .XT_CLK(xt_clk), .PREAMBLE_OK(pre_ok),
    .SYNC_OK(sync_ok), .PKT_OK(pkt_ok), .RX_FAULT(rx_flt), .TX_DONE(tx_done), .BATT_MV(batt_mv),
    .RX_ON(rx_on), .TX_START(tx_start), .XO_ON(xo_on), .RC_TRIM(trim), .LOW_BATT_PIN(lbd_pin),
    .INTERRUPT_REQUEST_LINE_N(irq_n));
  wkt_radio_model i_wkt_radio_model (.CLK(clk), .RX_ON(rx_on), .TX_START(tx_start),
    .SEND_PKT(send_pkt), .PKT_OK(pkt_ok), .TX_DONE(tx_done));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer looked at while settled; transfer ends at the next rising edge
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic sig(input int k);
    return k == 0 ? irq_n : (k == 1 ? rx_on : xo_on);
  endfunction : sig
  task wait_sig(input int k, input logic lvl);
    int n;
    n = 0;
    @(negedge clk);
    while (sig(k) !== lvl && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("wait", lvl, sig(k));
  endtask : wait_sig
  task flags(input int exp);
    apb(1'b0, WKT_OFS_FLAGS_RC, 0);
    chk("flags", exp, rd);
    repeat (2) @(posedge clk);
  endtask : flags
  // sleep aligned away from an rc edge
  task sleep_run(input int cfg);
    apb(1'b1, WKT_OFS_CONFIG, cfg);
    @(posedge rc_clk);
    repeat (6) @(posedge clk);
    apb(1'b1, WKT_OFS_CMD, 1 << WKT_CMD_SLEEP);
    ticks = 0;
  endtask : sleep_run
  task wait_ticks(input int t);
    while (ticks < t) @(posedge clk);
    repeat (10) @(posedge clk);
  endtask : wait_ticks
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, WKT_OFS_MANT, 0);
    chk("mant", 1, rd);
    apb(1'b0, 8'h30, 0);
    chk("slverr", 1, err);
    // boot calibration: rc faster than expected, trim steps down
    apb(1'b1, WKT_OFS_IRQ_EN, 1 << WKT_EV_CAL_DONE);
    apb(1'b1, WKT_OFS_CMD, 1 << WKT_CMD_BOOT);
    wait_sig(2, 1'b1);
    wait_sig(0, 1'b0);
    chk("trim", 8'h7f, trim);
    chk("xo", 0, xo_on);
    flags(16);
    // wake period and held interrupt
    apb(1'b1, WKT_OFS_IRQ_EN, 1 << WKT_EV_WAKE);
    for (int i = 0; i < 2; i++) begin
      mant = 1 + $unsigned($random(seed)) % 3;
      apb(1'b1, WKT_OFS_MANT, mant);
      sleep_run(1 << WKT_CFG_EN);
      wait_sig(0, 1'b0);
      chk("period", mant * 4, ticks);
      repeat (40) @(posedge clk);
      chk("irq held", 0, irq_n);
      flags(1);
      chk("irq free", 1, irq_n);
    end
    // crystal source, recalibration on the first expiry, timer then stopped
    mant = 1;
    apb(1'b1, WKT_OFS_MANT, mant);
    sleep_run((1 << WKT_CFG_EN) | (1 << WKT_CFG_CAL_EN) | (1 << WKT_CFG_SRC_XT));
    xticks = 0;
    wait_sig(0, 1'b0);
    chk("xt period", mant * 4, xticks);
    chk("recal", 1, xo_on);
    apb(1'b1, WKT_OFS_CONFIG, 0);
    wait_sig(2, 1'b0);
    chk("trim", 8'h7e, trim);
    flags(17);
    // battery rows: low, not low, detector off, low routed to the pin
    thr = 1500 + 50 * ($unsigned($random(seed)) % 32);
    apb(1'b1, WKT_OFS_THRESH, (thr - 1500) / 50);
    apb(1'b1, WKT_OFS_IRQ_EN, 1 << WKT_EV_LOW_BATT);
    for (int k = 0; k < 4; k++) begin
      batt_mv <= 12'(k == 1 ? thr : thr - 1);
      sleep_run((1 << WKT_CFG_EN) | (k != 2 ? 1 << WKT_CFG_LBD_EN : 0) | (k == 3 ? 1 << WKT_CFG_LBD_PIN : 0));
      wait_ticks(mant * 4);
      chk("irq", k != 0, irq_n);
      chk("pin", k == 3, lbd_pin);
      flags(k == 0 ? 9 : 1);
    end
    // listen window, then a packet ending it early
    expo = $unsigned($random(seed)) % 2;
    lsn = 1 + $unsigned($random(seed)) % 2;
    // period kept longer than two windows so no wake lands inside a listen
    apb(1'b1, WKT_OFS_MANT, 5);
    apb(1'b1, WKT_OFS_EXPO, expo);
    apb(1'b1, WKT_OFS_LISTEN, lsn);
    for (int k = 0; k < 4; k++) begin
      send_pkt <= k == 1;
      sleep_run((1 << WKT_CFG_EN) | (1 << WKT_CFG_LDC_RX));
      wait_sig(1, 1'b1);
      ticks = 0;
      // preamble earns a second window, sync cancelled by a fault does not
      if (k >= 2) begin
        @(posedge clk);
        pre_ok <= k == 2;
        sync_ok <= k == 3;
        @(posedge clk);
        pre_ok <= 1'b0;
        sync_ok <= 1'b0;
        rx_flt <= k == 3;
        @(posedge clk);
        rx_flt <= 1'b0;
      end
      wait_sig(1, 1'b0);
      chk("window", k == 1 ? 0 : (k == 2 ? 2 : 1) * lsn * 4 << expo, ticks);
      flags(k == 1 ? 3 : 1);
    end
    // transmit once per wake
    n_tx = 0;
    sleep_run((1 << WKT_CFG_EN) | (1 << WKT_CFG_LDC_TX));
    wait_ticks(20 << expo);
    chk("tx starts", 1, n_tx);
    flags(5);
    wrap_up();
  end
  // watchdog far past the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule : wkt_top_tb
`default_nettype wire
